// >>> bcd_stopwatch_timer_tb.sv
// Self-checking bench for the stopwatch timer
module bcd_stopwatch_timer_tb
  import bsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Short base period keeps one second at 1024 clocks
  localparam int BC = 4;
  typedef struct {logic w; logic [17:0] a; logic [3:0] s; logic [31:0] d, x; logic e;} bsw_row_t;
  logic              clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic              pwrite = 1'b0, pready, pslverr, irq, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [3:0]        pstrb = '0;
  int                bad_count = 0, samples_checked = 0, cyc = 0;
  bsw_row_t rows [15] = '{
    '{0, ADDR_CTRL, 4'hf, 0, 0, 0}, '{0, ADDR_HUND, 4'hf, 0, 0, 0},
    '{0, ADDR_TENTH, 4'hf, 0, 0, 0}, '{0, ADDR_MASK, 4'hf, 0, 0, 0},
    '{0, ADDR_FLAGS, 4'hf, 0, 0, 0}, '{1, ADDR_MASK, 4'hf, 4'hf, 0, 0},
    '{0, ADDR_MASK, 4'hf, 0, 4'hf, 0}, '{1, ADDR_MASK, 4'h0, 0, 0, 0},
    '{0, ADDR_MASK, 4'hf, 0, 4'hf, 0}, '{1, ADDR_HUND, 4'hf, 4'h5, 0, 0},
    '{0, ADDR_HUND, 4'hf, 0, 0, 0}, '{1, ADDR_CTRL, 4'hf, 4'h2, 0, 0},
    '{0, ADDR_CTRL, 4'hf, 0, 0, 0}, '{0, 18'h0_0000, 4'hf, 0, 0, 1},
    '{1, ADDR_MASK, 4'hf, 0, 0, 0}};
  bsw_top #(.BASE_CYCLES(BC)) dut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs about 1600 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk_d(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t data %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_b(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, g, x);
    end
  endtask
  // Psel stays high so back-to-back calls need no idle cycle
  task automatic bus(input logic w, input logic [17:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic rchk(input logic [17:0] a, input logic [31:0] x);
    bus(0, a, 4'hf, 0);
    chk_d(rd, x);
  endtask
  initial begin
    logic [3:0] old, nx, h;
    int last, lw, nw, nlong;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
      if (!rows[i].w) chk_d(rd, rows[i].x);
      chk_b(err, rows[i].e);
    end
    $display("register table done");
    bus(1, ADDR_CTRL, 4'hf, 1);
    old = 0;
    last = -1;
    lw = -1;
    nw = 0;
    nlong = 0;
    while (nw < 11) begin
      bus(0, ADDR_HUND, 4'hf, 0);
      if (rd[3:0] !== old) begin
        nx = (old == 4'h9) ? 4'h0 : old + 4'h1;
        chk_d(rd, 32'(nx));
        if (last >= 0) chk_b(cyc - last == 2 * BC || cyc - last == 3 * BC, 1);
        if (rd[3:0] == 4'h0) begin
          if (lw >= 0) chk_b(cyc - lw == 25 * BC || cyc - lw == 26 * BC, 1);
          if (lw >= 0 && cyc - lw == 26 * BC) nlong++;
          lw = cyc;
          nw++;
        end
        last = cyc;
        old = rd[3:0];
      end
    end
    // Stop before reading both digits so no carry lands between the reads
    bus(1, ADDR_CTRL, 4'hf, 0);
    chk_d(nlong, 6);
    rchk(ADDR_TENTH, 1);
    rchk(ADDR_FLAGS, 3);
    chk_b(irq, 0);
    bus(0, ADDR_HUND, 4'hf, 0);
    h = rd[3:0];
    idle(200);
    rchk(ADDR_HUND, 32'(h));
    rchk(ADDR_TENTH, 1);
    $display("count done");
    bus(1, ADDR_MASK, 4'hf, 1);
    idle(2);
    chk_b(irq, 1);
    bus(1, ADDR_FLAGS, 4'hf, 1);
    idle(2);
    chk_b(irq, 0);
    rchk(ADDR_FLAGS, 2);
    bus(1, ADDR_MASK, 4'hf, 3);
    idle(2);
    chk_b(irq, 1);
    bus(1, ADDR_FLAGS, 4'hf, 0);
    rchk(ADDR_FLAGS, 2);
    bus(1, ADDR_FLAGS, 4'hf, 2);
    idle(2);
    chk_b(irq, 0);
    $display("irq done");
    bus(1, ADDR_CTRL, 4'hf, 2);
    idle(50);
    rchk(ADDR_HUND, 0);
    rchk(ADDR_TENTH, 0);
    rchk(ADDR_CTRL, 0);
    bus(1, ADDR_CTRL, 4'hf, 1);
    idle(60);
    bus(1, ADDR_CTRL, 4'hf, 3);
    rchk(ADDR_HUND, 0);
    rchk(ADDR_CTRL, 1);
    idle(40);
    bus(0, ADDR_HUND, 4'hf, 0);
    chk_b(rd != 0, 1);
    $display("clear done");
    idle(3);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    @(posedge clock);
    rchk(ADDR_CTRL, 0);
    rchk(ADDR_HUND, 0);
    rchk(ADDR_TENTH, 0);
    rchk(ADDR_MASK, 0);
    rchk(ADDR_FLAGS, 0);
    idle(1);
    $display("reset done");
    end_sim();
  end
endmodule

// >>> bsw_digit.sv
// One BCD digit counter with clear and wrap pulse
module bsw_digit
  import bsw_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               step,
  input  wire logic               clear,
  output logic [DIGIT_W-1:0]      value,
  output logic                    wrap
);

  logic [DIGIT_W-1:0] value_reg;
  logic [DIGIT_W-1:0] value_next;
  logic               at_max;

  assign at_max     = (value_reg == DIGIT_MAX);
  assign wrap       = step & ~clear & at_max;
  assign value_next = clear ? DIGIT_RST :
                      (step ? (at_max ? DIGIT_RST : value_reg + DIGIT_ONE) : value_reg);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value_reg <= DIGIT_RST;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

// >>> bsw_pkg.sv
// Shared constants and helper functions for the BCD stopwatch timer
package bsw_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL  = 16'hff7c;
  localparam logic [15:0] IDX_HUND  = 16'hff7d;
  localparam logic [15:0] IDX_TENTH = 16'hff7e;
  localparam logic [15:0] IDX_MASK  = 16'hffe7;
  localparam logic [15:0] IDX_FLAGS = 16'hfff7;

  localparam int          ADDR_W    = 18;
  localparam int          DATA_W    = 32;
  localparam int          DIGIT_W   = 4;

  localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HUND  = {IDX_HUND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TENTH = {IDX_TENTH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK  = {IDX_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};

  // Field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam int IRQ_TENTH_BIT  = 0;
  localparam int IRQ_SECOND_BIT = 1;
  localparam int SPARE_TWO_BIT  = 2;
  localparam int SPARE_THREE_BIT = 3;

  // Reset values
  localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;
  localparam logic [3:0]         MASK_RST  = 4'h0;
  localparam logic [1:0]         FLAGS_RST = 2'h0;
  localparam logic               RUN_RST   = 1'b0;

  // BCD limits
  localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
  localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;

  // Timing: system clock and the 256 Hz base
  localparam int CLK_HZ   = 20_000_000;
  localparam int BASE_HZ  = 256;
  localparam int BASE_DIV = CLK_HZ / BASE_HZ;

  // Gap between hundredth increments, in base periods
  localparam logic [1:0] GAP_SHORT = 2'h2;
  localparam logic [1:0] GAP_LONG  = 2'h3;
  localparam logic [DIGIT_W-1:0] LONG_EXTRA_DIGIT = 4'h4;

  // Tenth periods of 26 base cycles fall on these tenths values (6 of 10)
  function automatic logic bsw_long_tenth(input logic [DIGIT_W-1:0] tenth);
    case (tenth)
      4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9: bsw_long_tenth = 1'b1;
      default: bsw_long_tenth = 1'b0;
    endcase
  endfunction

  // Gap before the hundredths digit steps from its present value
  function automatic logic [1:0] bsw_gap(input logic [DIGIT_W-1:0] hund,
                                         input logic long_tenth);
    if (hund[0] || (long_tenth && hund == LONG_EXTRA_DIGIT)) begin
      bsw_gap = GAP_LONG;
    end else begin
      bsw_gap = GAP_SHORT;
    end
  endfunction

endpackage

// >>> bsw_tick.sv
// Base divider and 2/3 spaced hundredth tick generator
module bsw_tick
  import bsw_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_DIV
)(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               run,
  input  wire logic               clear,
  input  wire logic [DIGIT_W-1:0] hund,
  input  wire logic [DIGIT_W-1:0] tenth,
  output logic                    tick
);

  localparam int PRE_W = $clog2(BASE_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYCLES - 1);
  localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);

  logic [PRE_W-1:0] pre_reg;
  logic [1:0]       gap_reg;
  logic             base_pulse;
  logic [1:0]       gap_target;

  // Base keeps running while stopped, so a short pause loses no phase
  assign base_pulse = (pre_reg == PRE_LAST);
  assign gap_target = bsw_gap(hund, bsw_long_tenth(tenth));
  assign tick       = run & ~clear & base_pulse & ((gap_reg + 2'h1) == gap_target);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
    end else if (base_pulse) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= 2'h0;
    end else if (clear || tick) begin
      gap_reg <= 2'h0;
    end else if (run && base_pulse) begin
      gap_reg <= gap_reg + 2'h1;
    end
  end

endmodule

// >>> bsw_top.sv
// BCD stopwatch timer with APB register slave and interrupt
module bsw_top
  import bsw_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_DIV
)(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq
);

  // Bus state
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;

  // Control and interrupt state
  logic              run_reg;
  logic              run_next;
  logic [3:0]        mask_reg;
  logic [3:0]        mask_next;
  logic [1:0]        flags_reg;
  logic [1:0]        flags_next;
  logic              irq_reg;
  logic              irq_next;

  // Counter wiring
  logic [DIGIT_W-1:0] hund_value;
  logic [DIGIT_W-1:0] tenth_value;
  logic               hund_tick;
  logic               hund_wrap;
  logic               tenth_wrap;
  logic               counter_clear;

  // Bus phase decode
  logic               setup_phase;
  logic               access_done;
  logic               wr_done;
  logic               lane0_wr;

  // Address decode
  logic               sel_ctrl;
  logic               sel_hund;
  logic               sel_tenth;
  logic               sel_mask;
  logic               sel_flags;
  logic               sel_any;

  // Write strobes per register
  logic               wr_ctrl;
  logic               wr_mask;
  logic               wr_flags;

  // Read views
  logic [DATA_W-1:0]  rd_ctrl;
  logic [DATA_W-1:0]  rd_hund;
  logic [DATA_W-1:0]  rd_tenth;
  logic [DATA_W-1:0]  rd_mask;
  logic [DATA_W-1:0]  rd_flags;

  // Events and clear masks
  logic [1:0]         flag_events;
  logic [1:0]         flag_clears;

  // ------------------------------------------------------------------
  // APB phases: no wait state, answer registered at the setup edge
  // ------------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_done     = access_done & pwrite;
  assign lane0_wr    = wr_done & pstrb[0];

  // ------------------------------------------------------------------
  // Address decode, word aligned only
  // ------------------------------------------------------------------
  assign sel_ctrl  = (paddr == ADDR_CTRL);
  assign sel_hund  = (paddr == ADDR_HUND);
  assign sel_tenth = (paddr == ADDR_TENTH);
  assign sel_mask  = (paddr == ADDR_MASK);
  assign sel_flags = (paddr == ADDR_FLAGS);
  assign sel_any   = sel_ctrl | sel_hund | sel_tenth | sel_mask | sel_flags;

  // Digit registers have no write strobe, so writes there do nothing
  assign wr_ctrl  = lane0_wr & sel_ctrl;
  assign wr_mask  = lane0_wr & sel_mask;
  assign wr_flags = lane0_wr & sel_flags;

  // ------------------------------------------------------------------
  // Control: run bit and clear strobe
  // ------------------------------------------------------------------
  assign counter_clear = wr_ctrl & pwdata[CTRL_CLR_BIT];
  assign run_next      = wr_ctrl ? pwdata[CTRL_RUN_BIT] : run_reg;

  // ------------------------------------------------------------------
  // Counter chain
  // ------------------------------------------------------------------
  // The clear write also loads the run bit from its bit 0: writing 3 runs on from zero,
  // writing 2 stops at zero.
  bsw_tick #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (run_reg),
    .clear   (counter_clear),
    .hund    (hund_value),
    .tenth   (tenth_value),
    .tick    (hund_tick)
  );

  bsw_digit u_hund (
    .clock   (clock),
    .reset_n (reset_n),
    .step    (hund_tick),
    .clear   (counter_clear),
    .value   (hund_value),
    .wrap    (hund_wrap)
  );

  // Tenths take the hundredths wrap as their approximate 10 Hz input
  bsw_digit u_tenth (
    .clock   (clock),
    .reset_n (reset_n),
    .step    (hund_wrap),
    .clear   (counter_clear),
    .value   (tenth_value),
    .wrap    (tenth_wrap)
  );

  // ------------------------------------------------------------------
  // Interrupt mask: two enables and two spare bits
  // ------------------------------------------------------------------
  assign mask_next = wr_mask ? pwdata[3:0] : mask_reg;

  // ------------------------------------------------------------------
  // Sticky flags; an event in the clearing cycle wins
  // ------------------------------------------------------------------
  assign flag_events[IRQ_TENTH_BIT]  = hund_wrap;
  assign flag_events[IRQ_SECOND_BIT] = tenth_wrap;
  assign flag_clears = wr_flags ? pwdata[1:0] : 2'b00;

  // Mask is not consulted here on purpose
  assign flags_next = (flags_reg & ~flag_clears) | flag_events;

  // Level request, built from next values so it tracks the flags exactly
  assign irq_next = |(flags_next & mask_next[1:0]);

  // ------------------------------------------------------------------
  // Read views, unused bits zero
  // ------------------------------------------------------------------
  // Clear bit always reads back as zero
  assign rd_ctrl  = {{(DATA_W-1){1'b0}}, run_reg};
  assign rd_hund  = {{(DATA_W-DIGIT_W){1'b0}}, hund_value};
  assign rd_tenth = {{(DATA_W-DIGIT_W){1'b0}}, tenth_value};
  assign rd_mask  = {{(DATA_W-4){1'b0}}, mask_reg};
  assign rd_flags = {{(DATA_W-2){1'b0}}, flags_reg};

  assign prdata_next = !setup_phase ? prdata_reg :
                       (pwrite      ? '0 :
                       (sel_ctrl    ? rd_ctrl :
                       (sel_hund    ? rd_hund :
                       (sel_tenth   ? rd_tenth :
                       (sel_mask    ? rd_mask :
                       (sel_flags   ? rd_flags : '0))))));

  // Ready only for the one access phase after each setup
  assign pready_next  = setup_phase;
  assign pslverr_next = setup_phase ? ~sel_any : (pslverr_reg & ~access_done);

  // ------------------------------------------------------------------
  // Bus output registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------------
  // Control and interrupt registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= RUN_RST;
    end else begin
      run_reg <= run_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

endmodule

// >>> bsw_top_chk.sv
// Port-level assertions for the stopwatch register slave
module bsw_chk
  import bsw_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_DIV
)(
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire mapped = paddr inside {ADDR_CTRL, ADDR_HUND, ADDR_TENTH, ADDR_MASK, ADDR_FLAGS};
  sequence s_set; psel && !penable; endsequence
  sequence s_rd(logic [ADDR_W-1:0] a); s_set ##0 !pwrite && paddr == a; endsequence
  property p_ready; s_set |=> pready ##1 !pready; endproperty
  property p_unmap; s_set ##0 !mapped |=> pslverr && pready && prdata == '0; endproperty
  property p_ctrl; s_rd(ADDR_CTRL) |=> prdata[31:1] == '0; endproperty
  property p_hund; s_rd(ADDR_HUND) |=> prdata <= 32'h0000_0009; endproperty
  property p_tenth; s_rd(ADDR_TENTH) |=> prdata <= 32'h0000_0009; endproperty
  property p_mask; s_rd(ADDR_MASK) |=> prdata[31:4] == '0; endproperty
  property p_flags; s_rd(ADDR_FLAGS) |=> prdata[31:2] == '0; endproperty
  property p_irq_rst; $rose(reset_n) |-> !irq; endproperty
  // Only a flag clear or a mask write may drop the request
  property p_irq_fell; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  // An error answer is only meaningful inside the access phase
  property p_err_ready; pslverr |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_ctrl: assert property (p_ctrl) else $error("clear bit read as one");
  a_hund: assert property (p_hund) else $error("hundredths not bcd");
  a_tenth: assert property (p_tenth) else $error("tenths not bcd");
  a_mask: assert property (p_mask) else $error("mask upper bits set");
  a_flags: assert property (p_flags) else $error("flag upper bits set");
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  a_irq_fell: assert property (p_irq_fell) else $error("irq fell unasked");
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
endmodule

bind bsw_top bsw_chk #(.BASE_CYCLES(BASE_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
);
